//--- src/aux_gpio_pkg.sv
package aux_gpio_pkg;

  // register addresses on the microcontroller's mapped register space
  localparam logic [15:0] ADDR_G_DIRECTION    = 16'h7FA0;
  localparam logic [15:0] ADDR_G_PIN_STATUS   = 16'h7FA1;
  localparam logic [15:0] ADDR_G_OUTPUT_LEVEL = 16'h7FA2;
  localparam logic [15:0] ADDR_H_DIRECTION    = 16'h7FA3;
  localparam logic [15:0] ADDR_H_PIN_STATUS   = 16'h7FA4;
  localparam logic [15:0] ADDR_H_OUTPUT_LEVEL = 16'h7FA5;
  localparam logic [15:0] ADDR_I_DIRECTION    = 16'h7FA6;
  localparam logic [15:0] ADDR_I_PIN_STATUS   = 16'h7FA7;
  localparam logic [15:0] ADDR_I_OUTPUT_LEVEL = 16'h7FA8;
  localparam logic [15:0] ADDR_HOST_OWNER     = 16'h7FA9;
  localparam logic [15:0] ADDR_H_BUFFER_KIND  = 16'h7FAA;
  localparam logic [15:0] ADDR_I_BUFFER_KIND  = 16'h7FAB;
  localparam logic [15:0] ADDR_PORT_BUF_KIND  = 16'h7FAC;

  // reset values
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [2:0] RESET_HOST_OWNER   = 3'h0;
  localparam logic [1:0] RESET_PORT_BUFKIND = 2'h0;

  // field positions in the host-ownership select register
  localparam int OWNER_BIT_G = 0;
  localparam int OWNER_BIT_H = 1;
  localparam int OWNER_BIT_I = 2;

  // field positions in the port pin buffer kind register
  localparam int PORT_BUF_BIT_OUT0  = 0;
  localparam int PORT_BUF_BIT_GPIO7 = 1;

  // read data has a one cycle latency
  localparam int READ_LATENCY = 1;

endpackage

//--- src/aux_gpio_controller_regs.sv
`timescale 1ns/10ps

// Summary of operation
// - twelve group registers plus port buffer register
// - group g registers at 7fa0 to 7fa2
// - group h registers at 7fa3 to 7fa5
// - group i registers at 7fa6 to 7fa8
// - direction bit one drives, zero listens
// - direction registers reset to zero
// - pin status reads live pin levels
// - groups h and i status alike
// - output registers read-write, reset zero
// - buffer kind registers at 7faa to 7fac
// - owner select at 7fa9, microcontroller only
// - pass-through ports mux group g with h
// - owner bits g h i pick host
// - register access ignores owner bits
// - buffer bit one means open-drain
module aux_gpio_controller_regs
  import aux_gpio_pkg::*;
#(
  parameter int GROUP_WIDTH = 8
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // microcontroller mapped register port
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_hit,
  // host-side copies of the group registers
  input  wire logic [7:0]  i_host_g_dir,
  input  wire logic [7:0]  i_host_g_out,
  input  wire logic [7:0]  i_host_h_dir,
  input  wire logic [7:0]  i_host_h_out,
  input  wire logic [7:0]  i_host_i_dir,
  input  wire logic [7:0]  i_host_i_out,
  // pass-through ports: when set, group h pins take group g's direction and level; h buffer kind still applies
  input  wire logic [7:0]  i_pass_through_en,
  // pin levels seen on the pads
  input  wire logic [7:0]  i_g_pin,
  input  wire logic [7:0]  i_h_pin,
  input  wire logic [7:0]  i_i_pin,
  // pad drive
  output logic      [7:0]  o_g_pin,
  output logic      [7:0]  o_g_pin_oe,
  output logic      [7:0]  o_h_pin,
  output logic      [7:0]  o_h_pin_oe,
  output logic      [7:0]  o_i_pin,
  output logic      [7:0]  o_i_pin_oe,
  // bank state for host logic and the standard port pins
  output logic      [2:0]  o_host_owner,
  output logic      [1:0]  o_port_open_drain
);

  // byte-wide registers cover exactly one group of pins
  if (GROUP_WIDTH != 8) begin : g_width_check
    $error("aux gpio groups must be eight pins wide");
  end

  typedef struct packed {
    logic [7:0] g_dir;
    logic [7:0] g_out;
    logic [7:0] h_dir;
    logic [7:0] h_out;
    logic [7:0] i_dir;
    logic [7:0] i_out;
    logic [2:0] owner;
    logic [7:0] h_buf;
    logic [7:0] i_buf;
    logic [1:0] port_buf;
    logic [7:0] rdata;
    logic       hit;
  } state_t;

  state_t state;
  state_t next_state;

  // effective direction and level per group after the ownership mux
  logic [7:0] g_dir_eff;
  logic [7:0] g_out_eff;
  logic [7:0] h_dir_eff;
  logic [7:0] h_out_eff;
  logic [7:0] i_dir_eff;
  logic [7:0] i_out_eff;

  // open-drain drives low only; push-pull drives both levels
  function automatic logic [7:0] pad_enable(input logic [7:0] dir,
                                            input logic [7:0] lvl,
                                            input logic [7:0] od);
    pad_enable = dir & ~(od & lvl);
  endfunction

  // register decode and update; no access path is gated by the owner bits
  always_comb begin
    next_state     = state;
    next_state.hit = 1'b0;
    if (i_wr) begin
      case (i_addr)
        ADDR_G_DIRECTION:    next_state.g_dir = i_wdata;
        ADDR_G_OUTPUT_LEVEL: next_state.g_out = i_wdata;
        ADDR_H_DIRECTION:    next_state.h_dir = i_wdata;
        ADDR_H_OUTPUT_LEVEL: next_state.h_out = i_wdata;
        ADDR_I_DIRECTION:    next_state.i_dir = i_wdata;
        ADDR_I_OUTPUT_LEVEL: next_state.i_out = i_wdata;
        ADDR_HOST_OWNER:     next_state.owner = i_wdata[2:0];
        ADDR_H_BUFFER_KIND:  next_state.h_buf = i_wdata;
        ADDR_I_BUFFER_KIND:  next_state.i_buf = i_wdata;
        ADDR_PORT_BUF_KIND:  next_state.port_buf = i_wdata[1:0];
        default: ; // status registers and unmapped: ignored
      endcase
    end
    if (i_rd) begin
      next_state.hit = 1'b1;
      case (i_addr)
        ADDR_G_DIRECTION:    next_state.rdata = state.g_dir;
        ADDR_G_PIN_STATUS:   next_state.rdata = i_g_pin;
        ADDR_G_OUTPUT_LEVEL: next_state.rdata = state.g_out;
        ADDR_H_DIRECTION:    next_state.rdata = state.h_dir;
        ADDR_H_PIN_STATUS:   next_state.rdata = i_h_pin;
        ADDR_H_OUTPUT_LEVEL: next_state.rdata = state.h_out;
        ADDR_I_DIRECTION:    next_state.rdata = state.i_dir;
        ADDR_I_PIN_STATUS:   next_state.rdata = i_i_pin;
        ADDR_I_OUTPUT_LEVEL: next_state.rdata = state.i_out;
        ADDR_HOST_OWNER:     next_state.rdata = {5'h0, state.owner};
        ADDR_H_BUFFER_KIND:  next_state.rdata = state.h_buf;
        ADDR_I_BUFFER_KIND:  next_state.rdata = state.i_buf;
        ADDR_PORT_BUF_KIND:  next_state.rdata = {6'h0, state.port_buf};
        default: begin
          next_state.rdata = RESET_BYTE; // unmapped reads as zero
          next_state.hit   = 1'b0;
        end
      endcase
    end
  end

  // all control state starts with pins as inputs, owned locally
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state.g_dir    <= RESET_BYTE;
      state.g_out    <= RESET_BYTE;
      state.h_dir    <= RESET_BYTE;
      state.h_out    <= RESET_BYTE;
      state.i_dir    <= RESET_BYTE;
      state.i_out    <= RESET_BYTE;
      state.owner    <= RESET_HOST_OWNER;
      state.h_buf    <= RESET_BYTE;
      state.i_buf    <= RESET_BYTE;
      state.port_buf <= RESET_PORT_BUFKIND;
      state.rdata    <= RESET_BYTE;
      state.hit      <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ownership picks which register set drives each group
  always_comb begin
    g_dir_eff = state.owner[OWNER_BIT_G] ? i_host_g_dir : state.g_dir;
    g_out_eff = state.owner[OWNER_BIT_G] ? i_host_g_out : state.g_out;
    h_dir_eff = state.owner[OWNER_BIT_H] ? i_host_h_dir : state.h_dir;
    h_out_eff = state.owner[OWNER_BIT_H] ? i_host_h_out : state.h_out;
    i_dir_eff = state.owner[OWNER_BIT_I] ? i_host_i_dir : state.i_dir;
    i_out_eff = state.owner[OWNER_BIT_I] ? i_host_i_out : state.i_out;
    // pass-through: group h pin takes group g's drive per bit
    h_dir_eff = (i_pass_through_en & g_dir_eff) |
                (~i_pass_through_en & h_dir_eff);
    h_out_eff = (i_pass_through_en & g_out_eff) |
                (~i_pass_through_en & h_out_eff);
  end

  // pad drive; group g has no buffer control so it is push-pull
  assign o_g_pin    = g_out_eff;
  assign o_g_pin_oe = g_dir_eff;
  assign o_h_pin    = h_out_eff;
  assign o_h_pin_oe = pad_enable(h_dir_eff, h_out_eff, state.h_buf);
  assign o_i_pin    = i_out_eff;
  assign o_i_pin_oe = pad_enable(i_dir_eff, i_out_eff, state.i_buf);

  assign o_rdata           = state.rdata;
  assign o_hit             = state.hit;
  assign o_host_owner      = state.owner;
  assign o_port_open_drain = state.port_buf;

endmodule

//--- dv/aux_gpio_pads.sv
`timescale 1ns/10ps
// pads of groups g, h, i: a driven pin shows the drive, else the outside
module aux_gpio_pads (
  input  wire logic [23:0] i_lvl,
  input  wire logic [23:0] i_oe,
  input  wire logic [23:0] i_ext,
  output logic      [23:0] o_pin
);
  assign o_pin = (i_lvl & i_oe) | (i_ext & ~i_oe);
endmodule

//--- dv/aux_gpio_monitor.sv
`timescale 1ns/10ps
module aux_gpio_monitor
  import aux_gpio_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  i_g_pin,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_hit,
  input wire logic [7:0]  o_g_pin_oe,
  input wire logic [2:0]  o_host_owner,
  input wire logic [1:0]  o_port_open_drain
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // read of the bank's thirteen addresses
  sequence rd_mapped;
    i_rd && i_addr >= ADDR_G_DIRECTION && i_addr <= ADDR_PORT_BUF_KIND;
  endsequence
  sequence rd_unmapped;
    i_rd && (i_addr < ADDR_G_DIRECTION || i_addr > ADDR_PORT_BUF_KIND);
  endsequence
  hit_mapped_a: assert property (rd_mapped |=> o_hit)
    else $error("no hit after mapped read");
  hit_unmapped_a: assert property (rd_unmapped |=> !o_hit && o_rdata == 0)
    else $error("unmapped read answered");
  hit_idle_a: assert property (!i_rd |=> !o_hit)
    else $error("hit without read");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved without read");
  status_live_a: assert property (i_rd && i_addr == ADDR_G_PIN_STATUS
    |=> o_rdata == $past(i_g_pin)) else $error("status not pin level");
  owner_wr_a: assert property (i_wr && i_addr == ADDR_HOST_OWNER
    |=> o_host_owner == $past(i_wdata[2:0])) else $error("owner bits");
  port_kind_a: assert property (i_wr && i_addr == ADDR_PORT_BUF_KIND
    |=> o_port_open_drain == $past(i_wdata[1:0])) else $error("port kind");
  g_dir_oe_a: assert property (i_wr && i_addr == ADDR_G_DIRECTION
    && !o_host_owner[0] |=> o_g_pin_oe == $past(i_wdata))
    else $error("group g enable");
endmodule
bind aux_gpio_controller_regs aux_gpio_monitor mon_u (.i_mclk(i_mclk),
  .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .i_g_pin(i_g_pin), .o_rdata(o_rdata), .o_hit(o_hit),
  .o_g_pin_oe(o_g_pin_oe), .o_host_owner(o_host_owner),
  .o_port_open_drain(o_port_open_drain));

//--- dv/aux_gpio_controller_regs_tb_top.sv
`timescale 1ns/10ps
module aux_gpio_controller_regs_tb_top
  import aux_gpio_pkg::*;
;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [15:0] addr = 0;
  logic [7:0] wd = 0, rdata, hdir = 8'h3C, pass = 0;
  logic [23:0] lvl, oe, pin, ext = 24'h5A_3C81;
  logic hit;
  int n_mismatch = 0, n_compared = 0;
  always #2 clk = ~clk;
  aux_gpio_controller_regs dut_u (.i_mclk(clk), .i_rst(rst), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata), .o_hit(hit),
    .i_host_g_dir(8'h00), .i_host_g_out(8'h00), .i_host_h_dir(hdir),
    .i_host_h_out(8'h00), .i_host_i_dir(8'h00), .i_host_i_out(8'h00),
    .i_pass_through_en(pass), .i_g_pin(pin[7:0]), .i_h_pin(pin[15:8]),
    .i_i_pin(pin[23:16]), .o_g_pin(lvl[7:0]), .o_g_pin_oe(oe[7:0]),
    .o_h_pin(lvl[15:8]), .o_h_pin_oe(oe[15:8]), .o_i_pin(lvl[23:16]),
    .o_i_pin_oe(oe[23:16]), .o_host_owner(), .o_port_open_drain());
  aux_gpio_pads pads_u (.i_lvl(lvl), .i_oe(oe), .i_ext(ext), .o_pin(pin));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrt(logic [15:0] a, logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask
  task automatic rdc(logic [15:0] a, logic [7:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    @(negedge clk) chk("rdata", rdata, exp);
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the sequence needs about 0.46 us
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    // reset values, then write and read back; owner and port kind masked
    for (int a = 16'h7FA0; a <= 16'h7FAC; a++) begin
      if (a inside {16'h7FA1, 16'h7FA4, 16'h7FA7}) continue;
      rdc(a[15:0], 8'h00);
      wrt(a[15:0], 8'hA5 ^ a[7:0]);
      rdc(a[15:0], (8'hA5 ^ a[7:0]) & (a == 16'h7FA9 ? 8'h07 :
        a == 16'h7FAC ? 8'h03 : 8'hFF));
    end
    // all pins listening, status reads the pad levels
    wrt(ADDR_HOST_OWNER, 8'h00);
    for (int g = 0; g < 3; g++) wrt(ADDR_G_DIRECTION + 16'(3 * g), 8'h00);
    rdc(ADDR_G_PIN_STATUS, 8'h81);
    rdc(ADDR_H_PIN_STATUS, 8'h3C);
    rdc(ADDR_I_PIN_STATUS, 8'h5A);
    wrt(ADDR_G_PIN_STATUS, 8'hFF);
    rdc(ADDR_G_DIRECTION, 8'h00);
    rdc(ADDR_G_PIN_STATUS, 8'h81);
    wrt(ADDR_G_DIRECTION, 8'hF0);
    wrt(ADDR_G_OUTPUT_LEVEL, 8'hAA);
    @(negedge clk) chk("g pad", pin[7:0], 8'hA1);
    // open-drain h pins never drive high
    wrt(ADDR_H_DIRECTION, 8'hFF);
    wrt(ADDR_H_OUTPUT_LEVEL, 8'h0F);
    wrt(ADDR_H_BUFFER_KIND, 8'hFF);
    @(negedge clk) chk("h oe", oe[15:8], 8'hF0);
    // host owns h: host copy drives, bank stays reachable
    wrt(ADDR_HOST_OWNER, 8'h02);
    @(negedge clk) chk("h oe host", oe[15:8], 8'h3C);
    rdc(ADDR_H_DIRECTION, 8'hFF);
    // pass-through: h pins follow group g
    wrt(ADDR_HOST_OWNER, 8'h00);
    wrt(ADDR_H_BUFFER_KIND, 8'h00);
    @(posedge clk) pass <= 8'hFF;
    @(negedge clk) chk("h oe pass", oe[15:8], 8'hF0);
    rdc(16'h7FAD, 8'h00);
    rdc(16'h7F9F, 8'h00);
    results();
  end
endmodule
